// ---- sim/flash_host_asserts.sv ----
// pin and handshake checker for the flash host controller
`timescale 1ns/10ps
module flash_host_asserts
(
  // clock, reset, user side
  input wire        mclk_i,
  input wire        rstn_i,
  input wire        req_i,
  input wire        busy_o,
  input wire        done_o,
  // flash pins
  input wire [15:0] addr_o,
  input wire        ce_n_o,
  input wire        oe_n_o,
  input wire        we_n_o,
  input wire [7:0]  data_pins_o,
  input wire        data_pins_oe_n_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_wend; !we_n_o ##1 we_n_o; endsequence
  property p_strobe; $fell(we_n_o) |-> !we_n_o [*3]; endproperty
  property p_inhibit; !we_n_o |-> !ce_n_o && oe_n_o; endproperty
  property p_read; !oe_n_o |-> !ce_n_o && we_n_o; endproperty
  property p_drive; !data_pins_oe_n_o |-> oe_n_o; endproperty
  property p_wdata; !we_n_o |-> !data_pins_oe_n_o; endproperty
  property p_hold;
    !we_n_o && !$past(we_n_o) |-> $stable(addr_o) && $stable(data_pins_o);
  endproperty
  // data is held past the strobe rise, then select, then the bus drops
  property p_wend;
    s_wend |-> !data_pins_oe_n_o ##1 ce_n_o ##1 data_pins_oe_n_o;
  endproperty
  property p_idle; !busy_o |-> we_n_o; endproperty
  property p_take; $rose(busy_o) |-> $past(req_i); endproperty
  property p_done; done_o |=> !done_o; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe short");
  a_inhibit: assert property (p_inhibit) else $error("bad write");
  a_read: assert property (p_read) else $error("bad read");
  a_drive: assert property (p_drive) else $error("bus clash");
  a_wdata: assert property (p_wdata) else $error("no data");
  a_hold: assert property (p_hold) else $error("bus moved");
  a_wend: assert property (p_wend) else $error("bad end");
  a_idle: assert property (p_idle) else $error("idle write");
  a_take: assert property (p_take) else $error("no request");
  a_done: assert property (p_done) else $error("long done");
endmodule // flash_host_asserts

// ---- sim/flash_host_test.sv ----
// self-checking bench for the flash host controller
`timescale 1ns/10ps
`include "flash_host_regs.vh"
module flash_host_test;
  reg         mclk_i = 0, rstn_i = 0, req_i = 0, clk_en_i = 1;
  reg  [2:0]  op_i = 0;
  reg  [15:0] addr_i = 0;
  reg  [7:0]  wdata_i = 0;
  wire        busy_o, done_o, timeout_o, ce_n_o, oe_n_o, we_n_o, doe_n;
  wire [7:0]  rdata_o, dout, din;
  wire [15:0] addr_o;
  integer     error_cnt = 0, compares = 0, n;
  flash_host dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
    .req_i(req_i), .op_i(op_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .busy_o(busy_o), .done_o(done_o), .timeout_o(timeout_o),
    .rdata_o(rdata_o), .addr_o(addr_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
    .we_n_o(we_n_o), .data_pins_o(dout), .data_pins_oe_n_o(doe_n),
    .data_pins_i(din));
  flash_model dev_u (.mclk_i(mclk_i), .addr_i(addr_o), .ce_n_i(ce_n_o),
    .oe_n_i(oe_n_o), .we_n_i(we_n_o), .host_i(dout), .host_oe_n_i(doe_n),
    .dq_o(din));
  initial forever #10 mclk_i = ~mclk_i;
  task chk(input string nm, input [23:0] seen, input [23:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task op(input [2:0] o, input [15:0] a, input [7:0] d);
  begin
    @(posedge mclk_i);
    op_i <= o;
    addr_i <= a;
    wdata_i <= d;
    req_i <= 1'b1;
    @(posedge mclk_i);
    req_i <= 1'b0;
    n = 0;
    do begin @(posedge mclk_i); #1; n = n + 1; end
    while (done_o !== 1'b1 && n < 20000);
    chk("done", n < 20000, 1);
    chk("busy", busy_o, 0);
    chk("device idle", dev_u.cnt_q == 0, 1);
    chk("timeout", timeout_o, 0);
  end
  endtask
  task rd(input [15:0] a, input [7:0] exp);
  begin
    op(0, a, 8'h00);
    chk("read", rdata_o, exp);
  end
  endtask
  task wrs(input integer k, input [23:0] last, input [7:0] c3);
  begin
    chk("writes", dev_u.log.size(), k);
    chk("last write", dev_u.log[k-1], last);
    if (k > 2) chk("unlock1", dev_u.log[0], 24'h55_55AA);
    if (k > 2) chk("unlock2", dev_u.log[1], 24'h2A_AA55);
    if (k > 3) chk("command", dev_u.log[2], {16'h5555, c3});
    if (k > 5) chk("unlock4", dev_u.log[3], 24'h55_55AA);
    if (k > 5) chk("unlock5", dev_u.log[4], 24'h2A_AA55);
    dev_u.log.delete();
  end
  endtask
  task t_program;
  begin
    op(1, 16'h1A5C, 8'h3C);
    wrs(4, 24'h1A_5C3C, 8'hA0);
    op(1, 16'h1A5D, 8'hC3);
    wrs(4, 24'h1A_5DC3, 8'hA0);
    rd(16'h1A5C, 8'h3C);
    rd(16'h1A5D, 8'hC3);
  end
  endtask
  task t_freeze;
  begin
    @(posedge mclk_i);
    clk_en_i <= 1'b0;
    op_i <= 3'h0;
    addr_i <= 16'h1A5C;
    req_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    chk("frozen busy", busy_o, 0);
    chk("frozen ce", ce_n_o, 1);
    @(posedge mclk_i);
    clk_en_i <= 1'b1;
    @(posedge mclk_i);
    req_i <= 1'b0;
    repeat (`FH_READ_CYC + 3) @(posedge mclk_i);
    #1;
    chk("read done", done_o, 1);
    chk("read frozen", rdata_o, 8'h3C);
  end
  endtask
  task t_ident;
  begin
    op(4, 16'h0000, 8'h00);
    wrs(3, 24'h55_5590, 8'h00);
    rd(16'h0000, dev_u.MAKER);
    rd(16'h0001, dev_u.DEVICE);
    op(5, 16'h1234, 8'h00);
    wrs(1, 24'h12_34F0, 8'h00);
    rd(16'h1A5C, 8'h3C);
    op(4, 16'h0000, 8'h00);
    op(6, 16'h0000, 8'h00);
    wrs(6, 24'h55_55F0, 8'h90);
    rd(16'h1A5D, 8'hC3);
  end
  endtask
  task t_erase;
  begin
    op(1, 16'h2000, 8'h5A);
    wrs(4, 24'h20_005A, 8'hA0);
    op(2, 16'h1A5C, 8'h00);
    wrs(6, 24'h10_0030, 8'h80);
    rd(16'h1A5D, 8'hFF);
    rd(16'h2000, 8'h5A);
    op(3, 16'h0000, 8'h00);
    wrs(6, 24'h55_5510, 8'h80);
    rd(16'h2000, 8'hFF);
  end
  endtask
  task finish_test;
  begin
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_program;
    t_freeze;
    t_ident;
    t_erase;
    finish_test;
  end
  // runs well under this span; a hang in polling ends here
  initial
  begin
    #1_000_000;
    error_cnt = error_cnt + 1;
    finish_test;
  end
endmodule // flash_host_test
bind flash_host flash_host_asserts chk_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .req_i(req_i), .busy_o(busy_o), .done_o(done_o), .addr_o(addr_o),
  .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
  .data_pins_o(data_pins_o), .data_pins_oe_n_o(data_pins_oe_n_o));

// ---- sim/flash_model.sv ----
// behavioural flash device on the far side of the host controller
`timescale 1ns/10ps
module flash_model
#(
  parameter BUSY_CYC = 50,
  parameter MAKER    = 8'h3C, // arbitrary value
  parameter DEVICE   = 8'h5A  // arbitrary value
)
(
  // clock and pins
  input  wire        mclk_i,
  input  wire [15:0] addr_i,
  input  wire        ce_n_i,
  input  wire        oe_n_i,
  input  wire        we_n_i,
  input  wire [7:0]  host_i,
  input  wire        host_oe_n_i,
  output wire [7:0]  dq_o
);
  reg [7:0]  mem [0:65535];
  reg [23:0] log [$];
  reg [15:0] a_q;
  reg [7:0]  d_q, pd_q, lst_q;
  reg [2:0]  st_q = 0;
  reg        we_q = 1, ce_q = 1, oe_q = 1, tg_q = 1, id_q = 0, pr_q = 0;
  integer    cnt_q = 0, i;
  wire       drv = !ce_n_i && !oe_n_i && we_n_i;
  wire [7:0] rd = (cnt_q > 0) ? {pr_q & ~pd_q[7], tg_q, 6'h00}
                : id_q ? (addr_i[0] ? DEVICE : MAKER) : mem[addr_i];
  // a released bus shows the inverse of its last level, never a held value
  assign dq_o = !host_oe_n_i ? host_i : drv ? rd : ~lst_q;
  task wr(input [15:0] a, input [7:0] d);
  begin
    log.push_back({a, d});
    st_q <= 0;
    if (cnt_q == 0)
      case (st_q)
        0: if (d == 8'hF0) id_q <= 0;
           else if (a[14:0] == 15'h5555 && d == 8'hAA) st_q <= 1;
        1, 5: if (a[14:0] == 15'h2AAA && d == 8'h55) st_q <= st_q + 1;
        4: if (a[14:0] == 15'h5555 && d == 8'hAA) st_q <= 5;
        2: if (a[14:0] == 15'h5555)
             case (d)
               8'hA0: st_q <= 3;
               8'h80: st_q <= 4;
               8'h90: id_q <= 1;
               8'hF0: id_q <= 0;
             endcase
        3:
        begin
          mem[a] = d;
          pd_q <= d;
          pr_q <= 1;
          cnt_q <= BUSY_CYC;
          tg_q <= 1;
        end
        6: if (d == 8'h30 || (d == 8'h10 && a[14:0] == 15'h5555))
        begin
          for (i = 0; i < 65536; i = i + 1)
            if (d == 8'h10 || i[15:12] == a[15:12]) mem[i] = 8'hFF;
          pr_q <= 0;
          cnt_q <= BUSY_CYC;
          tg_q <= 1;
        end
      endcase
  end
  endtask
  always @(posedge mclk_i)
  begin
    lst_q <= dq_o;
    we_q <= we_n_i;
    ce_q <= ce_n_i;
    oe_q <= oe_n_i;
    if (we_q && !we_n_i) a_q <= addr_i;
    if (!we_n_i) d_q <= dq_o;
    // strobes are sampled per cycle, so a sub-cycle glitch counts only if it spans a clock edge
    if (!we_q && we_n_i && !ce_q && oe_q) wr(a_q, d_q);
    if (!oe_q && !ce_q && (oe_n_i || ce_n_i) && cnt_q > 0) tg_q <= !tg_q;
    if (cnt_q > 0) cnt_q <= cnt_q - 1;
  end
endmodule // flash_model

// ---- verilog/flash_host.v ----
// host-side command sequencer driving a byte-wide parallel flash
// Functional notes
// - poll only after fourth/sixth write strobe
// - program: three unlock writes then target
// - erase: six writes, 30h sector, 10h chip
// - id entry: unlock writes ending 90h
// - id exit: single f0h or three-write
`timescale 1ns/10ps
`include "flash_host_regs.vh"
module flash_host
(
  // clock, reset, enable
  input  wire        mclk_i,
  input  wire        rstn_i,
  input  wire        clk_en_i,
  // user command port
  input  wire        req_i,
  input  wire [2:0]  op_i,
  input  wire [15:0] addr_i,
  input  wire [7:0]  wdata_i,
  output reg         busy_o,
  output reg         done_o,
  output reg         timeout_o,
  output reg  [7:0]  rdata_o,
  // flash pins
  output reg  [15:0] addr_o,
  output reg         ce_n_o,
  output reg         oe_n_o,
  output reg         we_n_o,
  output reg  [7:0]  data_pins_o,
  output reg         data_pins_oe_n_o,
  input  wire [7:0]  data_pins_i
);

  localparam [3:0] ST_IDLE   = 4'd0;
  localparam [3:0] ST_WSETUP = 4'd1;
  localparam [3:0] ST_WLOW   = 4'd2;
  localparam [3:0] ST_WHOLD  = 4'd3;
  localparam [3:0] ST_RSETUP = 4'd4;
  localparam [3:0] ST_RWAIT  = 4'd5;
  localparam [3:0] ST_POLL2  = 4'd6;
  localparam [3:0] ST_DONE   = 4'd7;

  reg [3:0]  state_q;
  reg [2:0]  op_q;
  reg [2:0]  step_q;
  reg [2:0]  nsteps_q;
  reg [15:0] uaddr_q;
  reg [7:0]  udata_q;
  reg [7:0]  cnt_q;
  reg [7:0]  prev_q;
  reg        polling_q;
  reg [31:0] polls_q;

  // number of bus writes for each operation
  function [2:0] op_len;
    input [2:0] op;
    begin
      case (op)
        `FH_OP_PROGRAM:  op_len = 3'd4;
        `FH_OP_SECTOR:   op_len = 3'd6;
        `FH_OP_CHIP:     op_len = 3'd6;
        `FH_OP_ID_ENTRY: op_len = 3'd3;
        `FH_OP_ID_EXIT:  op_len = 3'd1;
        `FH_OP_ID_EXIT3: op_len = 3'd3;
        default:         op_len = 3'd0;
      endcase
    end
  endfunction

  // address of write number step; unlock steps use low fifteen bits
  function [15:0] step_addr;
    input [2:0]  op;
    input [2:0]  step;
    input [15:0] ua;
    begin
      case (step)
        3'd1:    step_addr = `FH_ADDR_UNLOCK2;
        3'd3:    step_addr = (op == `FH_OP_PROGRAM) ? ua :
                             `FH_ADDR_UNLOCK1;
        3'd4:    step_addr = `FH_ADDR_UNLOCK2;
        3'd5:    step_addr = (op == `FH_OP_SECTOR) ?
                             {ua[15:`FH_SECTOR_LSB], 12'h000} :
                             `FH_ADDR_UNLOCK1;
        default: step_addr = (op == `FH_OP_ID_EXIT) ? ua :
                             `FH_ADDR_UNLOCK1;
      endcase
    end
  endfunction

  function [7:0] step_data;
    input [2:0] op;
    input [2:0] step;
    input [7:0] ud;
    begin
      case (step)
        3'd0:    step_data = (op == `FH_OP_ID_EXIT) ? `FH_CMD_ID_EXIT :
                             `FH_DATA_UNLOCK1;
        3'd1:    step_data = `FH_DATA_UNLOCK2;
        3'd2:
          case (op)
            `FH_OP_PROGRAM:  step_data = `FH_CMD_PROGRAM;
            `FH_OP_ID_ENTRY: step_data = `FH_CMD_ID_ENTRY;
            `FH_OP_ID_EXIT3: step_data = `FH_CMD_ID_EXIT;
            default:         step_data = `FH_CMD_ERASE;
          endcase
        3'd3:    step_data = (op == `FH_OP_PROGRAM) ? ud :
                             `FH_DATA_UNLOCK1;
        3'd4:    step_data = `FH_DATA_UNLOCK2;
        default: step_data = (op == `FH_OP_SECTOR) ? `FH_CMD_SECTOR :
                             `FH_CMD_CHIP;
      endcase
    end
  endfunction

  wire busy_op = (op_q == `FH_OP_PROGRAM) || (op_q == `FH_OP_SECTOR) ||
                 (op_q == `FH_OP_CHIP);

  always @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q          <= ST_IDLE;
      op_q             <= 3'h0;
      step_q           <= 3'h0;
      nsteps_q         <= 3'h0;
      uaddr_q          <= 16'h0000;
      udata_q          <= 8'h00;
      cnt_q            <= 8'h00;
      prev_q           <= 8'h00;
      polling_q        <= 1'b0;
      polls_q          <= 32'h0000_0000;
      busy_o           <= 1'b0;
      done_o           <= 1'b0;
      timeout_o        <= 1'b0;
      rdata_o          <= 8'h00;
      addr_o           <= 16'h0000;
      ce_n_o           <= 1'b1;   // standby
      oe_n_o           <= 1'b1;
      we_n_o           <= 1'b1;
      data_pins_o      <= 8'h00;
      data_pins_oe_n_o <= 1'b1;
    end
    else if (clk_en_i)
    begin
      done_o <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          ce_n_o <= 1'b1;
          oe_n_o <= 1'b1;
          we_n_o <= 1'b1;
          data_pins_oe_n_o <= 1'b1;
          if (req_i)
          begin
            op_q      <= op_i;
            uaddr_q   <= addr_i;
            udata_q   <= wdata_i;
            nsteps_q  <= op_len(op_i);
            step_q    <= 3'h0;
            polling_q <= 1'b0;
            polls_q   <= 32'h0000_0000;
            timeout_o <= 1'b0;
            busy_o    <= 1'b1;
            cnt_q     <= 8'h00;
            // unknown op codes finish at once instead of spinning writes
            state_q   <= (op_i == `FH_OP_READ) ? ST_RSETUP :
                         (op_len(op_i) == 3'd0) ? ST_DONE : ST_WSETUP;
          end
        end
        ST_WSETUP:
        begin
          // oe held high first so the write is never inhibited
          oe_n_o           <= 1'b1;
          addr_o           <= step_addr(op_q, step_q, uaddr_q);
          data_pins_o      <= step_data(op_q, step_q, udata_q);
          data_pins_oe_n_o <= 1'b0;
          ce_n_o           <= 1'b0;
          cnt_q   <= 8'h00;
          state_q <= ST_WLOW;
        end
        ST_WLOW:
        begin
          // address stable before the strobe falls, data before it rises
          we_n_o <= 1'b0;
          cnt_q  <= cnt_q + 8'h01;
          // strobe low well beyond the glitch filter width
          if (cnt_q == `FH_STROBE_CYC)
          begin
            we_n_o  <= 1'b1;
            cnt_q   <= 8'h00;
            state_q <= ST_WHOLD;
          end
        end
        ST_WHOLD:
        begin
          ce_n_o <= 1'b1;
          cnt_q  <= cnt_q + 8'h01;
          if (cnt_q == `FH_SETUP_CYC)
          begin
            data_pins_oe_n_o <= 1'b1;
            cnt_q <= 8'h00;
            if (step_q + 3'h1 == nsteps_q)
            begin
              // status only after the final strobe of the sequence
              polling_q <= busy_op;
              state_q   <= busy_op ? ST_RSETUP : ST_DONE;
            end
            else
            begin
              step_q  <= step_q + 3'h1;
              state_q <= ST_WSETUP;
            end
          end
        end
        ST_RSETUP:
        begin
          we_n_o           <= 1'b1;
          data_pins_oe_n_o <= 1'b1;
          addr_o  <= uaddr_q;
          ce_n_o  <= 1'b0;
          oe_n_o  <= 1'b0;
          cnt_q   <= 8'h00;
          state_q <= ST_RWAIT;
        end
        ST_RWAIT:
        begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == `FH_READ_CYC)
          begin
            ce_n_o  <= 1'b1;
            oe_n_o  <= 1'b1;
            rdata_o <= data_pins_i;
            // keep the earlier read so two successive reads can be compared
            prev_q  <= rdata_o;
            state_q <= polling_q ? ST_POLL2 : ST_DONE;
          end
        end
        ST_POLL2:
        begin
          // finished when two reads in a row agree on the toggle bit
          polls_q <= polls_q + 32'h0000_0001;
          if (polls_q != 32'h0000_0000 &&
              rdata_o[`FH_TOGGLE_BIT] == prev_q[`FH_TOGGLE_BIT])
            state_q <= ST_DONE;
          else if (polls_q == `FH_POLL_LIMIT)
          begin
            timeout_o <= 1'b1;
            state_q   <= ST_DONE;
          end
          else
            state_q <= ST_RSETUP;
        end
        ST_DONE:
        begin
          busy_o  <= 1'b0;
          done_o  <= 1'b1;
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // flash_host

// ---- verilog/flash_host_regs.vh ----
// constants for the parallel flash host controller
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH
`define FH_ADDR_UNLOCK1   16'h5555
`define FH_ADDR_UNLOCK2   16'h2AAA
`define FH_ADDR_ID_MAKER  16'h0000
`define FH_ADDR_ID_DEVICE 16'h0001
`define FH_DATA_UNLOCK1   8'hAA
`define FH_DATA_UNLOCK2   8'h55
`define FH_CMD_PROGRAM    8'hA0
`define FH_CMD_ERASE      8'h80
`define FH_CMD_SECTOR     8'h30
`define FH_CMD_CHIP       8'h10
`define FH_CMD_ID_ENTRY   8'h90
`define FH_CMD_ID_EXIT    8'hF0
`define FH_OP_READ        3'h0
`define FH_OP_PROGRAM     3'h1
`define FH_OP_SECTOR      3'h2
`define FH_OP_CHIP        3'h3
`define FH_OP_ID_ENTRY    3'h4
`define FH_OP_ID_EXIT     3'h5
`define FH_OP_ID_EXIT3    3'h6
`define FH_TOGGLE_BIT     6
`define FH_POLL_BIT       7
`define FH_SECTOR_LSB     12
`define FH_STROBE_NS      60
`define FH_STROBE_CYC     ((`FH_STROBE_NS + 19) / 20)
`define FH_SETUP_NS       20
`define FH_SETUP_CYC      ((`FH_SETUP_NS + 19) / 20)
`define FH_READ_NS        100
`define FH_READ_CYC       ((`FH_READ_NS + 19) / 20)
`define FH_POLL_LIMIT     32'd2_000_000
`endif
